/* File: pcirq_top.sv */
// Pin change interrupt logic with interrupt entry and return sequencing.
// Assumes pins and core strobes are synchronous to pclk, APB master on the bus side,
// and a synchronous stack memory that answers a read on the following cycle.
//
// Functional notes
// - Entry lasts at least four cycles before vector.
// - Program counter pushed during entry.
// - Vector jump takes three cycles after entry.
// - Multi-cycle instruction finishes before entry starts.
// - Wake from sleep adds four entry cycles.
// - Return: four cycles, pop PC, SP+2, set GIE.
// - One instruction runs after enable before service.
// - Enabled pin change sets flag bit 5.
// - Flag, GIE and group enable take vector.
// - Flag clears on entry or written one.
// - Flag register bits 4:0 read zero.
// - Mask A pins 0-7 need high group enable.
// - Mask B pins 8-11 need low group enable.
// - Mask B pins 12-15 need high group enable.
// - Cleared mask bit always disables its pin.
`timescale 1ns/10ps
`default_nettype none

module pcirq_top
   import pcirq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PCIRQ_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PCIRQ_NPIN-1:0] change_watched_pins,
   input wire logic insn_boundary,
   input wire logic core_sleeping,
   input wire logic wake_done,
   input wire logic reti_req,
   input wire logic [15:0] core_pc,
   output logic core_hold,
   output logic wake_req,
   output logic stack_wr_en,
   output logic stack_rd_en,
   output logic [15:0] stack_addr,
   output logic [7:0] stack_wdata,
   input wire logic [7:0] stack_rdata,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic pc_load,
   output logic [15:0] pc_restore,
   output logic irq
);

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   // The slave never inserts wait states; read data is captured in the setup cycle.
   wire logic bus_setup = psel & ~penable;
   wire logic bus_access = psel & penable;
   wire logic bus_wr = bus_access & pwrite;
   wire logic bus_rd = bus_access & ~pwrite;
   wire logic hit_mask_a = (paddr == PCIRQ_ADDR_MASK_A);
   wire logic hit_mask_b = (paddr == PCIRQ_ADDR_MASK_B);
   wire logic hit_group = (paddr == PCIRQ_ADDR_GROUP);
   wire logic hit_flag = (paddr == PCIRQ_ADDR_FLAG);
   wire logic hit_core = (paddr == PCIRQ_ADDR_CORE);
   wire logic hit_state = (paddr == PCIRQ_ADDR_STATE);
   wire logic hit_evt = (paddr == PCIRQ_ADDR_EVT);
   wire logic hit_evt_msk = (paddr == PCIRQ_ADDR_EVT_MSK);
   wire logic hit_any = hit_mask_a | hit_mask_b | hit_group | hit_flag | hit_core | hit_state |
                        hit_evt | hit_evt_msk;

   assign pready = 1'b1;
   assign pslverr = bus_access & ~hit_any;

   // ------------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------------
   logic [7:0] mask_a_r;
   logic [7:0] mask_b_r;
   logic group_low_r;
   logic group_high_r;
   logic flag_r;
   logic flag_nxt;
   logic gie_r;
   logic gie_nxt;
   logic gie_hold_r;
   logic gie_hold_nxt;
   logic [PCIRQ_NEVT-1:0] evt_r;
   logic [PCIRQ_NEVT-1:0] evt_nxt;
   logic [PCIRQ_NEVT-1:0] evt_msk_r;
   logic [31:0] prdata_r;
   logic [PCIRQ_NPIN-1:0] pin_meta_r;
   logic [PCIRQ_NPIN-1:0] pin_sync_r;
   logic [PCIRQ_NPIN-1:0] pin_prev_r;
   pcirq_state_t state_r;
   pcirq_state_t state_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic [15:0] sp_r;
   logic [15:0] sp_nxt;
   logic [15:0] pc_save_r;
   logic [15:0] pc_restore_r;
   logic [15:0] pc_restore_nxt;
   logic vector_fetch_r;
   logic pc_load_r;

   // ------------------------------------------------------------------
   // Pin change detection
   // ------------------------------------------------------------------
   // Two flops synchronise each pin; the comparison uses only the second flop and the
   // previous sample, so either edge counts as a change.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         pin_prev_r <= '0;
      end else begin
         pin_meta_r <= change_watched_pins;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Per-pin enable: mask bit and group enable must both be one.
   logic [PCIRQ_NPIN-1:0] pin_en;
   genvar gi;
   generate
      for (gi = 0; gi < PCIRQ_NPIN; gi++) begin : g_pin_en
         if (gi < 8) begin : g_a
            assign pin_en[gi] = mask_a_r[gi] & group_high_r;
         end else if (gi < 12) begin : g_bl
            assign pin_en[gi] = mask_b_r[gi-8] & group_low_r;
         end else begin : g_bh
            assign pin_en[gi] = mask_b_r[gi-8] & group_high_r;
         end
      end
   endgenerate

   wire logic [PCIRQ_NPIN-1:0] pin_change = pin_sync_r ^ pin_prev_r;
   wire logic change_evt = |(pin_change & pin_en);

   // ------------------------------------------------------------------
   // Sequencer decisions
   // ------------------------------------------------------------------
   // Pending only while flag, global enable and a group enable all stand, and not in the
   // instruction that follows the enable.
   wire logic pending = flag_r & gie_r & (group_low_r | group_high_r) & ~gie_hold_r;
   wire logic start_entry = (state_r == PCIRQ_IDLE) & pending & insn_boundary & ~core_sleeping;
   wire logic start_sleep = (state_r == PCIRQ_IDLE) & pending & core_sleeping;
   wire logic cnt_last = (cnt_r == PCIRQ_CNT_ONE);
   wire logic entry_begin = start_entry | ((state_r == PCIRQ_WAKE) & cnt_last);
   wire logic ret_done = (state_r == PCIRQ_RETURN) & cnt_last;
   wire logic start_ret = (state_r == PCIRQ_IDLE) & ~pending & reti_req;
   wire logic entry_done = (state_r == PCIRQ_ENTRY) & cnt_last;
   wire logic jump_done = (state_r == PCIRQ_JUMP) & cnt_last;

   // Sequencer next state and cycle counter.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - PCIRQ_CNT_ONE;
      case (state_r)
         PCIRQ_IDLE: begin
            if (start_entry) begin
               state_nxt = PCIRQ_ENTRY;
               cnt_nxt = PCIRQ_ENTRY_CYC;
            end else if (start_sleep) begin
               state_nxt = PCIRQ_SLEEP_WAIT;
            end else if (start_ret) begin
               state_nxt = PCIRQ_RETURN;
               cnt_nxt = PCIRQ_RET_CYC;
            end
         end
         PCIRQ_SLEEP_WAIT: begin
            if (wake_done) begin
               state_nxt = PCIRQ_WAKE;
               cnt_nxt = PCIRQ_WAKE_CYC;
            end
         end
         PCIRQ_WAKE: begin
            if (cnt_last) begin
               state_nxt = PCIRQ_ENTRY;
               cnt_nxt = PCIRQ_ENTRY_CYC;
            end
         end
         PCIRQ_ENTRY: begin
            if (cnt_last) begin
               state_nxt = PCIRQ_JUMP;
               cnt_nxt = PCIRQ_JUMP_CYC;
            end
         end
         PCIRQ_JUMP: begin
            if (cnt_last) begin
               state_nxt = PCIRQ_IDLE;
            end
         end
         PCIRQ_RETURN: begin
            if (cnt_last) begin
               state_nxt = PCIRQ_IDLE;
            end
         end
         default: begin
            state_nxt = PCIRQ_IDLE;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PCIRQ_IDLE;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Stack traffic
   // ------------------------------------------------------------------
   // Entry writes the low byte in its first cycle and the high byte in its second; the
   // return reads both in its first two cycles and captures them one cycle later.
   wire logic in_entry = (state_r == PCIRQ_ENTRY);
   wire logic in_ret = (state_r == PCIRQ_RETURN);
   wire logic push_lo = in_entry & (cnt_r == PCIRQ_ENTRY_CYC);
   wire logic push_hi = in_entry & (cnt_r == PCIRQ_ENTRY_CYC - PCIRQ_CNT_ONE);
   wire logic pop_hi = in_ret & (cnt_r == PCIRQ_RET_CYC);
   wire logic pop_lo = in_ret & (cnt_r == PCIRQ_RET_CYC - PCIRQ_CNT_ONE);
   wire logic cap_hi = in_ret & (cnt_r == PCIRQ_RET_CYC - PCIRQ_CNT_ONE);
   wire logic cap_lo = in_ret & (cnt_r == PCIRQ_RET_CYC - PCIRQ_SP_STEP[2:0]);

   assign stack_wr_en = push_lo | push_hi;
   assign stack_rd_en = pop_hi | pop_lo;
   assign stack_wdata = push_lo ? pc_save_r[7:0] : pc_save_r[15:8];
   assign stack_addr = push_lo ? sp_r :
                       push_hi ? sp_r - 16'h0001 :
                       pop_hi ? sp_r + 16'h0001 :
                       sp_r + PCIRQ_SP_STEP;

   // Stack pointer and restored program counter.
   always_comb begin
      sp_nxt = sp_r;
      pc_restore_nxt = pc_restore_r;
      if (entry_done) begin
         sp_nxt = sp_r - PCIRQ_SP_STEP;
      end
      if (ret_done) begin
         sp_nxt = sp_r + PCIRQ_SP_STEP;
      end
      if (cap_hi) begin
         pc_restore_nxt = {stack_rdata, pc_restore_r[7:0]};
      end
      if (cap_lo) begin
         pc_restore_nxt = {pc_restore_r[15:8], stack_rdata};
      end
   end

   // The program counter is frozen where entry starts: at the boundary, or at the end of wake-up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_r <= PCIRQ_RST_SP;
         pc_save_r <= '0;
         pc_restore_r <= '0;
         vector_fetch_r <= 1'b0;
         pc_load_r <= 1'b0;
      end else begin
         sp_r <= sp_nxt;
         pc_save_r <= entry_begin ? core_pc : pc_save_r;
         pc_restore_r <= pc_restore_nxt;
         vector_fetch_r <= entry_done;
         pc_load_r <= ret_done;
      end
   end

   assign core_hold = (state_r != PCIRQ_IDLE);
   assign wake_req = (state_r == PCIRQ_SLEEP_WAIT);
   assign vector_fetch = vector_fetch_r;
   assign vector_addr = PCIRQ_VECTOR_ADDR;
   assign pc_load = pc_load_r;
   assign pc_restore = pc_restore_r;

   // ------------------------------------------------------------------
   // Flag, global enable and event status
   // ------------------------------------------------------------------
   // A new change wins over a clear in the same cycle, so no edge is lost.
   wire logic flag_w1c = bus_wr & hit_flag & pwdata[PCIRQ_FLAG_BIT];
   wire logic gie_wr = bus_wr & hit_core;
   wire logic gie_rise = gie_wr & pwdata[PCIRQ_GIE_BIT] & ~gie_r;
   wire logic [PCIRQ_NEVT-1:0] evt_set = {ret_done, entry_done, change_evt};
   wire logic evt_rdclr = bus_rd & hit_evt;

   always_comb begin
      flag_nxt = flag_r;
      if (flag_w1c | entry_begin) begin
         flag_nxt = 1'b0;
      end
      if (change_evt) begin
         flag_nxt = 1'b1;
      end
      gie_nxt = gie_r;
      if (gie_wr) begin
         gie_nxt = pwdata[PCIRQ_GIE_BIT];
      end
      if (entry_begin) begin
         gie_nxt = 1'b0;
      end
      if (ret_done) begin
         gie_nxt = 1'b1;
      end
      gie_hold_nxt = gie_hold_r;
      if (insn_boundary) begin
         gie_hold_nxt = 1'b0;
      end
      if (gie_rise | ret_done) begin
         gie_hold_nxt = 1'b1;
      end
      // Only bits captured for the read are cleared; a bit set after the setup cycle survives.
      evt_nxt = (evt_rdclr ? (evt_r & ~prdata_r[PCIRQ_NEVT-1:0]) : evt_r) | evt_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
         gie_r <= 1'b0;
         gie_hold_r <= 1'b0;
         evt_r <= '0;
      end else begin
         flag_r <= flag_nxt;
         gie_r <= gie_nxt;
         gie_hold_r <= gie_hold_nxt;
         evt_r <= evt_nxt;
      end
   end

   assign irq = |(evt_r & evt_msk_r);

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_a_r <= PCIRQ_RST_MASK_A;
         mask_b_r <= PCIRQ_RST_MASK_B;
         group_low_r <= 1'b0;
         group_high_r <= 1'b0;
         evt_msk_r <= '0;
      end else if (bus_wr) begin
         if (hit_mask_a) begin
            mask_a_r <= pwdata[7:0];
         end
         if (hit_mask_b) begin
            mask_b_r <= pwdata[7:0];
         end
         if (hit_group) begin
            group_low_r <= pwdata[PCIRQ_GRP_LOW_BIT];
            group_high_r <= pwdata[PCIRQ_GRP_HIGH_BIT];
         end
         if (hit_evt_msk) begin
            evt_msk_r <= pwdata[PCIRQ_NEVT-1:0];
         end
      end
   end

   // Read mux; unmapped addresses read zero. Unused bits read zero as well.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (hit_mask_a) begin
         rd_mux[7:0] = mask_a_r;
      end
      if (hit_mask_b) begin
         rd_mux[7:0] = mask_b_r;
      end
      if (hit_group) begin
         rd_mux[PCIRQ_GRP_LOW_BIT] = group_low_r;
         rd_mux[PCIRQ_GRP_HIGH_BIT] = group_high_r;
      end
      if (hit_flag) begin
         rd_mux[PCIRQ_FLAG_BIT] = flag_r;
      end
      if (hit_core) begin
         rd_mux[PCIRQ_GIE_BIT] = gie_r;
      end
      if (hit_state) begin
         rd_mux[2:0] = state_r;
         rd_mux[31:16] = sp_r;
      end
      if (hit_evt) begin
         rd_mux[PCIRQ_NEVT-1:0] = evt_r;
      end
      if (hit_evt_msk) begin
         rd_mux[PCIRQ_NEVT-1:0] = evt_msk_r;
      end
   end

   // Captured in the setup cycle so prdata comes from a flop with no wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (bus_setup) begin
         prdata_r <= rd_mux;
      end
   end

   assign prdata = prdata_r;

endmodule : pcirq_top

`default_nettype wire

/* File: pcirq_pkg.sv */
// Constants, register map and sequencer states of the pin change interrupt block.
// Assumes a single 250 MHz system clock and 32-bit APB register access.
package pcirq_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int PCIRQ_AW = 8;
   localparam logic [PCIRQ_AW-1:0] PCIRQ_IDX_MASK_B = 8'h22;   // Index of mask register B.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_IDX_MASK_A = 8'h23;   // Index of mask register A.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_MASK_B = 8'h88;  // Four times its index.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_MASK_A = 8'h8C;  // Four times its index.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_GROUP = 8'h00;   // Interrupt mask register (group enables).
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_FLAG = 8'h04;    // Flag register.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_CORE = 8'h08;    // Core status word.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_STATE = 8'h0C;   // Sequencer state and stack pointer.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_EVT = 8'h10;     // Event status, cleared by read.
   localparam logic [PCIRQ_AW-1:0] PCIRQ_ADDR_EVT_MSK = 8'h14; // Event mask.

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int PCIRQ_FLAG_BIT = 5;       // Pin change flag position.
   localparam int PCIRQ_GRP_LOW_BIT = 4;    // Group enable for pins 8 to 11.
   localparam int PCIRQ_GRP_HIGH_BIT = 5;   // Group enable for pins 0 to 7 and 12 to 15.
   localparam int PCIRQ_GIE_BIT = 7;        // Global interrupt enable in the core status word.
   localparam int PCIRQ_NPIN = 16;
   localparam int PCIRQ_NEVT = 3;
   localparam int PCIRQ_EVT_CHANGE = 0;
   localparam int PCIRQ_EVT_ENTRY = 1;
   localparam int PCIRQ_EVT_RETURN = 2;
   localparam logic [7:0] PCIRQ_RST_MASK_A = 8'hC8;
   localparam logic [7:0] PCIRQ_RST_MASK_B = 8'hFF;
   localparam logic [15:0] PCIRQ_RST_SP = 16'h01FF;
   localparam logic [15:0] PCIRQ_VECTOR_ADDR = 16'h0002;  // Pin change vector word address.

   // ------------------------------------------------------------------
   // Timing, in clock cycles
   // ------------------------------------------------------------------
   localparam logic [2:0] PCIRQ_ENTRY_CYC = 3'h4;   // Least interrupt entry time.
   localparam logic [2:0] PCIRQ_JUMP_CYC = 3'h3;    // Vector jump time.
   localparam logic [2:0] PCIRQ_WAKE_CYC = 3'h4;    // Extra entry time after wake-up.
   localparam logic [2:0] PCIRQ_RET_CYC = 3'h4;     // Return time.
   localparam logic [15:0] PCIRQ_SP_STEP = 16'h0002;
   localparam logic [2:0] PCIRQ_CNT_ONE = 3'h1;

   // Sequencer states.
   typedef enum logic [2:0] {
      PCIRQ_IDLE,
      PCIRQ_SLEEP_WAIT,
      PCIRQ_WAKE,
      PCIRQ_ENTRY,
      PCIRQ_JUMP,
      PCIRQ_RETURN
   } pcirq_state_t;

endpackage : pcirq_pkg

/* File: pcirq_props.sv */
// Checker for the pin change interrupt block: entry, jump, wake and return timing.
// Assumes it is bound to pcirq_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module pcirq_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic insn_boundary,
   input wire logic [15:0] core_pc,
   input wire logic core_hold,
   input wire logic wake_req,
   input wire logic stack_wr_en,
   input wire logic stack_rd_en,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   input wire logic [7:0] stack_rdata,
   input wire logic vector_fetch,
   input wire logic pc_load,
   input wire logic [15:0] pc_restore
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Program counter halves as plain nets, so that $past sees a signal.
   wire logic [7:0] pc_lo = core_pc[7:0];
   wire logic [7:0] pc_hi = core_pc[15:8];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // First cycle of a push and of a pop.
   sequence push_start_s;
      stack_wr_en && !$past(stack_wr_en);
   endsequence
   sequence pop_start_s;
      stack_rd_en && !$past(stack_rd_en);
   endsequence
   sequence jump_tail_s;
      core_hold [*3] ##1 !core_hold;
   endsequence

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   entry_len_a: assert property (push_start_s |-> ##1 stack_wr_en ##1 !vector_fetch [*2] ##1 vector_fetch)
      else $error("Vector fetch not four cycles into entry.");
   push_data_a: assert property (push_start_s |-> stack_wdata == $past(pc_lo)
      ##1 (stack_wdata == $past(pc_hi, 2) && stack_addr == $past(stack_addr) - 16'h0001))
      else $error("Program counter push wrong.");
   jump_len_a: assert property (vector_fetch |-> jump_tail_s)
      else $error("Vector jump not three cycles.");
   start_bound_a: assert property ($rose(core_hold) && stack_wr_en |-> $past(insn_boundary))
      else $error("Entry started inside an instruction.");
   wake_len_a: assert property ($fell(wake_req) && core_hold |-> !stack_wr_en [*4] ##1 stack_wr_en)
      else $error("Wake-up did not add four cycles.");
   ret_len_a: assert property (pc_load |-> $past(stack_rd_en, 4) && $past(stack_rd_en, 3) && !core_hold)
      else $error("Return not four cycles.");
   pop_order_a: assert property (pop_start_s |=> stack_rd_en && stack_addr == $past(stack_addr) + 16'h0001)
      else $error("Pop order wrong.");
   restore_val_a: assert property (pc_load |-> pc_restore == {$past(stack_rdata, 3), $past(stack_rdata, 2)})
      else $error("Restored program counter wrong.");
endmodule : pcirq_props

bind pcirq_top pcirq_props i_pcirq_props (.pclk(pclk), .presetn(presetn), .insn_boundary(insn_boundary),
   .core_pc(core_pc), .core_hold(core_hold), .wake_req(wake_req), .stack_wr_en(stack_wr_en),
   .stack_rd_en(stack_rd_en), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
   .stack_rdata(stack_rdata), .vector_fetch(vector_fetch), .pc_load(pc_load), .pc_restore(pc_restore));
`default_nettype wire

/* File: pcirq_pin_model.sv */
// Far side of the block: watched pins and the stack memory.
// Assumes pin toggles are requested one cycle at a time by the bench.
`timescale 1ns/10ps
`default_nettype none

module pcirq_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] flip,
   output logic [15:0] pins,
   input wire logic stack_wr_en,
   input wire logic stack_rd_en,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   output logic [7:0] stack_rdata
);
   logic [7:0] mem [0:511];

   // Pins toggle on request; read data is valid only the cycle after a read,
   // otherwise it keeps changing so a late capture cannot pass by luck.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= 16'h0000;
         stack_rdata <= 8'h00;
      end else begin
         pins <= pins ^ flip;
         if (stack_wr_en) begin
            mem[stack_addr[8:0]] <= stack_wdata;
         end
         stack_rdata <= stack_rd_en ? mem[stack_addr[8:0]] : ~stack_rdata;
      end
   end
endmodule : pcirq_pin_model
`default_nettype wire

/* File: pin_change_irq_and_response_bench.sv */
// Self-checking bench: APB register access, pin change detection, entry, wake and return.
// Assumes pcirq_pkg, pcirq_top, the pin model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module pin_change_irq_and_response_bench;
   import pcirq_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] flip = 16'h0000;
   logic insn_boundary = 1'b0;
   logic core_sleeping = 1'b0;
   logic wake_done = 1'b0;
   logic reti_req = 1'b0;
   logic [15:0] core_pc = 16'hA5C3;
   wire logic [31:0] prdata;
   wire logic [15:0] pins, stack_addr, vector_addr, pc_restore;
   wire logic [7:0] stack_wdata, stack_rdata;
   wire logic pready, pslverr, core_hold, wake_req, stack_wr_en, stack_rd_en, vector_fetch, pc_load, irq;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic err;
   logic [7:0] n;
   logic ex_bit;

   pcirq_top i_pcirq_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .change_watched_pins(pins), .insn_boundary, .core_sleeping, .wake_done, .reti_req,
      .core_pc, .core_hold, .wake_req, .stack_wr_en, .stack_rd_en, .stack_addr, .stack_wdata,
      .stack_rdata, .vector_fetch, .vector_addr, .pc_load, .pc_restore, .irq);
   pcirq_pin_model i_pcirq_pin_model (.pclk, .presetn, .flip, .pins, .stack_wr_en, .stack_rd_en,
      .stack_addr, .stack_wdata, .stack_rdata);

   // Clock, and a cycle ceiling that cuts a hang short.
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask : rchk

   // Toggle one pin for a cycle, then let the synchroniser settle.
   task automatic toggle(input int p);
      @(posedge pclk);
      flip <= 16'h0001 << p;
      @(posedge pclk);
      flip <= 16'h0000;
      repeat (5) @(posedge pclk);
   endtask : toggle

   task automatic pulse_boundary();
      @(posedge pclk);
      insn_boundary <= 1'b1;
      @(posedge pclk);
      insn_boundary <= 1'b0;
   endtask : pulse_boundary

   // Counts edges from a request until vector fetch or program counter reload.
   task automatic cnt(input logic ret);
      n = 8'h00;
      do begin
         @(posedge pclk);
         n++;
      end while ((ret ? pc_load : vector_fetch) !== 1'b1 && n < 8'hC8);
   endtask : cnt

   task automatic reti();
      @(posedge pclk);
      reti_req <= 1'b1;
      @(posedge pclk);
      reti_req <= 1'b0;
      cnt(1'b1);
   endtask : reti

   task automatic end_of_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(PCIRQ_ADDR_MASK_B, 32'h000000FF, "mask_b");
      rchk(PCIRQ_ADDR_MASK_A, 32'h000000C8, "mask_a");
      rchk(8'h40, 32'h0, "unmapped");
      `CHK("slverr", 1'b1, err)
      // Every pin against every group setting, masks open then closed.
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, PCIRQ_ADDR_MASK_A, m ? 32'h0 : 32'hFF);
         apb(1'b1, PCIRQ_ADDR_MASK_B, m ? 32'h0 : 32'hFF);
         for (int g = 0; g < 4; g++) begin
            apb(1'b1, PCIRQ_ADDR_GROUP, 32'(g) << 4);
            for (int p = 0; p < 16; p++) begin
               toggle(p);
               ex_bit = (m == 0) && ((p >= 8 && p < 12) ? g[0] : g[1]);
               rchk(PCIRQ_ADDR_FLAG, {26'h0, ex_bit, 5'h00}, "flag");
               apb(1'b1, PCIRQ_ADDR_FLAG, 32'h20);
               rchk(PCIRQ_ADDR_FLAG, 32'h0, "flag_w1c");
            end
         end
      end
      `CHK("irq_masked", 1'b0, irq)
      // Entry, delayed by a long instruction and by the enabling instruction.
      apb(1'b1, PCIRQ_ADDR_MASK_A, 32'hFF);
      apb(1'b1, PCIRQ_ADDR_GROUP, 32'h30);
      apb(1'b1, PCIRQ_ADDR_EVT_MSK, 32'h7);
      apb(1'b0, PCIRQ_ADDR_EVT, 32'h0);
      apb(1'b1, PCIRQ_ADDR_CORE, 32'h80);
      `CHK("irq_clr", 1'b0, irq)
      toggle(0);
      `CHK("irq_set", 1'b1, irq)
      repeat (6) @(posedge pclk);
      `CHK("hold_mid", 1'b0, core_hold)
      pulse_boundary();
      repeat (2) @(posedge pclk);
      `CHK("hold_sei", 1'b0, core_hold)
      pulse_boundary();
      cnt(1'b0);
      `CHK("entry_cyc", 8'h05, n)
      `CHK("vec_addr", PCIRQ_VECTOR_ADDR, vector_addr)
      while (core_hold === 1'b1) @(posedge pclk);
      rchk(PCIRQ_ADDR_FLAG, 32'h0, "flag_auto");
      rchk(PCIRQ_ADDR_EVT, 32'h3, "evt");
      rchk(PCIRQ_ADDR_STATE, 32'h01FD0000, "sp_push");
      reti();
      `CHK("ret_cyc", 8'h05, n)
      `CHK("pc_back", 16'hA5C3, pc_restore)
      rchk(PCIRQ_ADDR_CORE, 32'h80, "gie");
      rchk(PCIRQ_ADDR_STATE, 32'h01FF0000, "sp_pop");
      // Wake from sleep: four extra cycles after the start-up time.
      pulse_boundary();
      core_sleeping <= 1'b1;
      core_pc <= 16'h5A3C;
      toggle(1);
      while (wake_req !== 1'b1) @(posedge pclk);
      repeat (3) @(posedge pclk);
      wake_done <= 1'b1;
      @(posedge pclk);
      wake_done <= 1'b0;
      cnt(1'b0);
      `CHK("wake_cyc", 8'h09, n)
      while (core_hold === 1'b1) @(posedge pclk);
      core_sleeping <= 1'b0;
      reti();
      `CHK("pc_back2", 16'h5A3C, pc_restore)
      end_of_test();
   end
endmodule : pin_change_irq_and_response_bench
`default_nettype wire
